/* File: hw/vbi_data_inserter_pkg.sv */
// Constants shared by the vertical-blanking data inserter
`default_nettype none
package vbi_data_inserter_pkg;
    // Register map (word addresses on the plain register port)
    localparam logic [3:0] ADDR_WSS_LOW   = 4'h0;
    localparam logic [3:0] ADDR_WSS_MID   = 4'h1;
    localparam logic [3:0] ADDR_WSS_CTRL  = 4'h2;
    localparam logic [3:0] ADDR_TEXT_CTRL = 4'h3;
    localparam logic [3:0] ADDR_TEXT_LINE = 4'h4;
    localparam logic [3:0] ADDR_STATUS    = 4'h5;
    // Field positions
    localparam int WSS_ENABLE_BIT   = 7;
    localparam int PAL_MODE_BIT     = 0;
    localparam int TEXT_ENABLE_BIT  = 4;
    localparam int TIMING_LSB       = 0;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Line and payload figures
    localparam logic [9:0] WSS_LINE       = 10'h017;
    localparam int         WSS_BITS       = 14;
    localparam logic [23:0] WSS_RUNIN     = 24'h1F1C71;
    localparam logic [23:0] WSS_START     = 24'h3C1E3C;
    localparam int         PREAMBLE_BITS  = 48;
    localparam int         WSS_SYMBOL_CLK = 5;
    // Teletext and signaling timing
    localparam int TEXT_BITS      = 360;
    localparam int TEXT_GROUP     = 37;
    localparam int CLOCK_KHZ      = 27000;
    localparam int TEXT_OFFSET_NS = 10200;
    localparam int WSS_END_NS     = 42500;
    localparam int TEXT_START_CLK = (TEXT_OFFSET_NS * CLOCK_KHZ + 999999) / 1000000;
    localparam int WSS_END_CLK    = (WSS_END_NS * CLOCK_KHZ) / 1000000;
    localparam int WSS_START_CLK  = TEXT_START_CLK;
    localparam int LINE_CLK       = 1728;
endpackage
`default_nettype wire

/* File: hw/vbi_data_inserter.sv */
// Wide-screen signaling and teletext inserter for the blanking interval
//
// Our own choices: the address-and-strobe port and the register addresses.
`default_nettype none

// Functional notes
// - Signaling word placed on line 23 only, and only in PAL mode.
// - No signaling output in non-PAL standards, whatever the enable.
// - Fourteen payload bits, preceded by run-in then start code.
// - W0-W7 from low byte bits 0-7, W8-W13 from mid byte; W0 first.
// - Signaling word started only while its enable bit is one; once started it runs to its end.
// - Active video passes from 42.5 us after sync edge to line end.
// - First teletext bit appears 10.2 us after leading sync edge.
// - Request rising and falling edges placed by programmable timing.
// - Request window spans 360 bits at 6.9375 Mbit/s with timing zero.
// - No window and no requests while teletext enable is zero.
// - Every 37 teletext bits take exactly 144 system clocks.
// - Bits 10, 19, 28, 37 of each group last three clocks, others four.
// - Sequence continues until 360 bits taken, then insertion stops.
// - Bits resampled by sequencer and phase filter, band limited.
// - Every teletext line timed alike; line selection per configuration.
module vbi_data_inserter #(
    parameter int LINE_CLOCKS = vbi_data_inserter_pkg::LINE_CLK
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    input  wire logic       hsync_start,
    input  wire logic [9:0] line_number,
    input  wire logic [9:0] video_in,
    input  wire logic       text_data_in,
    output logic            text_request,
    output logic [9:0]      video_out
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE_ST = 3'h1,
        WSS_ST  = 3'h2,
        TEXT_ST = 3'h4
    } phase_type;

    typedef struct packed {
        logic [7:0]  wss_low;
        logic [7:0]  wss_mid;
        logic [7:0]  wss_ctrl;
        logic [7:0]  text_ctrl;
        logic [7:0]  text_line;
        logic [7:0]  rdata;
        phase_type   phase;
        logic [10:0] line_clk;
        logic [5:0]  sym_idx;
        logic [2:0]  sym_clk;
        logic [8:0]  bit_cnt;
        logic [5:0]  grp_idx;
        logic [1:0]  bit_clk;
        logic [15:0] tap;
        logic        req;
        logic        cur_bit;
        logic [9:0]  prev_lvl;
        logic [9:0]  video;
        logic        wss_sent;
    } state_type;

    state_type cur_reg;
    state_type cur_next;

    localparam logic [9:0] LVL_HIGH  = 10'h1F4;
    localparam logic [9:0] LVL_BLANK = 10'h0F0;

    // Last bit_clk count (bit length in clocks minus one) from its 1-based position within a group
    function automatic logic [1:0] bit_len(input logic [5:0] idx);
        if (idx == 6'h0A || idx == 6'h13 || idx == 6'h1C || idx == 6'h25)
            bit_len = 2'h2;
        else
            bit_len = 2'h3;
    endfunction

    function automatic logic [9:0] cur_bit_level(input logic b);
        cur_bit_level = b ? LVL_HIGH : LVL_BLANK;
    endfunction

    // Preamble and payload symbol for signaling
    function automatic logic wss_symbol(input logic [5:0] idx, input logic [13:0] payload);
        logic [47:0] pre;
        pre = {vbi_data_inserter_pkg::WSS_RUNIN, vbi_data_inserter_pkg::WSS_START};
        if (idx < 6'(vbi_data_inserter_pkg::PREAMBLE_BITS))
            wss_symbol = pre[6'd47 - idx];
        else
            wss_symbol = payload[4'(idx - 6'(vbi_data_inserter_pkg::PREAMBLE_BITS))];
    endfunction

    logic        pal_mode;
    logic        wss_enable;
    logic        text_enable;
    logic [3:0]  timing;
    logic [13:0] payload;
    logic [10:0] req_open;
    logic        line_selected;

    // payload order, W0 at bit 0
    assign payload       = {cur_reg.wss_mid[5:0], cur_reg.wss_low};
    assign pal_mode      = cur_reg.wss_ctrl[vbi_data_inserter_pkg::PAL_MODE_BIT];
    assign wss_enable    = cur_reg.wss_ctrl[vbi_data_inserter_pkg::WSS_ENABLE_BIT];
    assign text_enable   = cur_reg.text_ctrl[vbi_data_inserter_pkg::TEXT_ENABLE_BIT];
    assign timing        = cur_reg.text_ctrl[vbi_data_inserter_pkg::TIMING_LSB +: 4];
    // per-line selection over lines 7..14 of the blanking interval
    assign line_selected = line_number >= 10'h007 && line_number <= 10'h00E
                           && cur_reg.text_line[3'(line_number - 10'h007)];
    // request leads the insertion point by the source delay
    assign req_open      = 11'(vbi_data_inserter_pkg::TEXT_START_CLK) - 11'(timing);

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb
    begin
        logic [10:0] sum;
        sum = 11'h000;
        cur_next = cur_reg;
        cur_next.rdata = 8'h00;
        // Line counter parks at line end so a missing sync cannot retrigger insertion
        if (hsync_start)
            cur_next.line_clk = 11'h000;
        else if (cur_reg.line_clk == 11'(LINE_CLOCKS - 1))
            cur_next.line_clk = cur_reg.line_clk;
        else
            cur_next.line_clk = cur_reg.line_clk + 11'h001;
        cur_next.tap = {cur_reg.tap[14:0], text_data_in};
        cur_next.video = video_in;

        if (reg_write)
        begin
            unique case (reg_addr)
                vbi_data_inserter_pkg::ADDR_WSS_LOW:   cur_next.wss_low   = reg_wdata;
                vbi_data_inserter_pkg::ADDR_WSS_MID:   cur_next.wss_mid   = reg_wdata;
                vbi_data_inserter_pkg::ADDR_WSS_CTRL:  cur_next.wss_ctrl  = reg_wdata;
                vbi_data_inserter_pkg::ADDR_TEXT_CTRL: cur_next.text_ctrl = reg_wdata;
                vbi_data_inserter_pkg::ADDR_TEXT_LINE: cur_next.text_line = reg_wdata;
                default: ;
            endcase
        end
        if (reg_read)
        begin
            unique case (reg_addr)
                vbi_data_inserter_pkg::ADDR_WSS_LOW:   cur_next.rdata = cur_reg.wss_low;
                vbi_data_inserter_pkg::ADDR_WSS_MID:   cur_next.rdata = cur_reg.wss_mid;
                vbi_data_inserter_pkg::ADDR_WSS_CTRL:  cur_next.rdata = cur_reg.wss_ctrl;
                vbi_data_inserter_pkg::ADDR_TEXT_CTRL: cur_next.rdata = cur_reg.text_ctrl;
                vbi_data_inserter_pkg::ADDR_TEXT_LINE: cur_next.rdata = cur_reg.text_line;
                vbi_data_inserter_pkg::ADDR_STATUS:
                    cur_next.rdata = {4'h0, cur_reg.wss_sent, cur_reg.phase};
                default: cur_next.rdata = 8'h00;
            endcase
        end

        unique case (cur_reg.phase)
            IDLE_ST:
            begin
                cur_next.req = 1'b0;
                if (cur_reg.line_clk == 11'(vbi_data_inserter_pkg::WSS_START_CLK)
                    && line_number == vbi_data_inserter_pkg::WSS_LINE && pal_mode && wss_enable)
                begin
                    cur_next.phase = WSS_ST;
                    cur_next.sym_idx = 6'h00;
                    cur_next.sym_clk = 3'h0;
                    cur_next.wss_sent = 1'b1;
                end
                else if (text_enable && line_selected && cur_reg.line_clk == req_open)
                begin
                    cur_next.phase = TEXT_ST;
                    cur_next.req = 1'b1;
                    cur_next.bit_cnt = 9'h000;
                    cur_next.grp_idx = 6'h01;
                    cur_next.bit_clk = 2'h0;
                end
            end
            WSS_ST:
            begin
                cur_next.sym_clk = cur_reg.sym_clk + 3'h1;
                if (cur_reg.sym_clk == 3'(vbi_data_inserter_pkg::WSS_SYMBOL_CLK - 1))
                begin
                    cur_next.sym_clk = 3'h0;
                    cur_next.sym_idx = cur_reg.sym_idx + 6'h01;
                    if (cur_reg.sym_idx == 6'(vbi_data_inserter_pkg::PREAMBLE_BITS
                                              + vbi_data_inserter_pkg::WSS_BITS - 1))
                        cur_next.phase = IDLE_ST;
                end
                if (cur_reg.line_clk >= 11'(vbi_data_inserter_pkg::WSS_END_CLK) || hsync_start)
                    cur_next.phase = IDLE_ST;
            end
            TEXT_ST:
            begin
                // variable bit lengths, 144 clocks per group
                cur_next.bit_clk = cur_reg.bit_clk + 2'h1;
                if (cur_reg.bit_clk == bit_len(cur_reg.grp_idx))
                begin
                    cur_next.bit_clk = 2'h0;
                    cur_next.bit_cnt = cur_reg.bit_cnt + 9'h001;
                    cur_next.grp_idx = (cur_reg.grp_idx == 6'(vbi_data_inserter_pkg::TEXT_GROUP))
                                       ? 6'h01 : cur_reg.grp_idx + 6'h01;
                    if (cur_reg.bit_cnt == 9'(vbi_data_inserter_pkg::TEXT_BITS - 1))
                    begin
                        cur_next.phase = IDLE_ST;
                        cur_next.req = 1'b0;
                    end
                end
                if (!text_enable || hsync_start)
                begin
                    cur_next.phase = IDLE_ST;
                    cur_next.req = 1'b0;
                end
            end
            default: cur_next.phase = IDLE_ST;
        endcase

        // source delay absorbed by tap select
        cur_next.cur_bit = cur_reg.tap[timing];
        cur_next.prev_lvl = cur_reg.video;
        unique case (cur_reg.phase)
            WSS_ST:
                cur_next.video = wss_symbol(cur_reg.sym_idx, payload) ? LVL_HIGH : LVL_BLANK;
            TEXT_ST:
            begin
                // two-tap phase interpolation for band limiting
                sum = 11'(cur_bit_level(cur_reg.cur_bit)) + 11'(cur_reg.prev_lvl);
                cur_next.video = sum[10:1];
            end
            default: ;
        endcase
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur_reg <= '0;
            cur_reg.wss_low   <= vbi_data_inserter_pkg::RESET_BYTE;
            cur_reg.wss_mid   <= vbi_data_inserter_pkg::RESET_BYTE;
            cur_reg.wss_ctrl  <= vbi_data_inserter_pkg::RESET_BYTE;
            cur_reg.text_ctrl <= vbi_data_inserter_pkg::RESET_BYTE;
            cur_reg.text_line <= vbi_data_inserter_pkg::RESET_BYTE;
            cur_reg.phase     <= IDLE_ST;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    assign reg_rdata    = cur_reg.rdata;
    assign text_request = cur_reg.req;
    assign video_out    = cur_reg.video;
endmodule // vbi_data_inserter
`default_nettype wire

/* File: verification/vbi_data_inserter_assertions.sv */
// Port-level checker for the blanking-interval data inserter
`default_nettype none
module vbi_data_inserter_checker (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       hsync_start,
    input wire logic [9:0] line_number,
    input wire logic [9:0] video_in,
    input wire logic       text_request,
    input wire logic [9:0] video_out
);
    logic [7:0]  ctl_reg;
    logic [7:0]  txt_reg;
    logic [10:0] lc;
    logic [10:0] wid;
    // Shadows of the two control registers, taken from the write strobe
    always_ff @(posedge clock)
    begin
        lc  <= hsync_start ? 11'h000 : lc + 11'h001;
        wid <= text_request ? wid + 11'h001 : 11'h000;
        if (rst)
        begin
            ctl_reg <= 8'h00;
            txt_reg <= 8'h00;
        end
        else if (reg_write && reg_addr == 4'h2)
            ctl_reg <= reg_wdata;
        else if (reg_write && reg_addr == 4'h3)
            txt_reg <= reg_wdata;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_WSS_LINE_ONLY: assert property (
        line_number > 10'h00E && line_number != 10'h017 && $past(line_number) != 10'h017
        |-> video_out == $past(video_in)) else $error("signaling seen off its line");
    AST_WSS_NOT_PAL: assert property (
        !ctl_reg[0] && !$past(ctl_reg[0]) && line_number > 10'h00E |-> video_out == $past(video_in))
        else $error("signaling seen outside PAL");
    AST_WSS_DISABLED: assert property (
        !ctl_reg[7] && !$past(ctl_reg[7]) && line_number > 10'h00E |-> video_out == $past(video_in))
        else $error("signaling seen while disabled");
    AST_WSS_ACTIVE: assert property (
        line_number == 10'h017 && ctl_reg[0] && ctl_reg[7] && lc == 11'h12C
        |-> video_out inside {10'h1F4, 10'h0F0}) else $error("signaling symbol missing");
    AST_LATE_VIDEO: assert property (
        line_number > 10'h00E && lc > 11'h47E |-> video_out == $past(video_in))
        else $error("late video not passed");
    AST_REQ_START: assert property (
        $rose(text_request) |-> (lc + txt_reg[3:0]) inside {[11'h112:11'h117]})
        else $error("request edge misplaced");
    AST_REQ_WIDTH: assert property (
        $fell(text_request) && !$past(hsync_start) |-> wid == 11'h57A)
        else $error("request window width wrong");
    AST_REQ_DISABLED: assert property (
        !txt_reg[4] && !$past(txt_reg[4]) |-> !text_request) else $error("request while disabled");
    AST_REQ_LINES: assert property (
        text_request |-> line_number inside {[10'h007:10'h00E]}) else $error("request on wrong line");
endmodule // vbi_data_inserter_checker
bind vbi_data_inserter vbi_data_inserter_checker chk_i (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .hsync_start(hsync_start), .line_number(line_number),
    .video_in(video_in), .text_request(text_request), .video_out(video_out));
`default_nettype wire

/* File: verification/text_source_model.sv */
// Behavioural teletext source answering the request line
`default_nettype none
module text_source_model (
    input  wire logic       clock,
    input  wire logic       text_request,
    input  wire logic [3:0] source_request_delay,
    output logic            text_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pipe = 16'h0000;
    logic [15:0] pat  = 16'h0063;
    logic [5:0]  pos  = 6'h00;
    logic [1:0]  tick = 2'h0;
    logic        live;
    assign live = pipe[source_request_delay];
    initial text_data_in = 1'b0;
    always @(posedge clock)
    begin
        pipe <= {pipe[14:0], text_request};
        tick <= tick + 2'h1;
        if (!live)
        begin
            pos <= 6'h00;
            tick <= 2'h0;
            text_data_in <= !text_data_in;
        end
        else if (tick == ((pos != 6'h00 && pos % 9 == 0) ? 2'h2 : 2'h3))
        begin
            tick <= 2'h0;
            pos <= (pos == 6'h24) ? 6'h00 : pos + 6'h01;
            pat <= {pat[14:0], pat[15] ^ pat[13] ^ pat[12] ^ pat[10]};
            text_data_in <= pat[0];
        end
    end
endmodule // text_source_model
`default_nettype wire

/* File: verification/vbi_data_inserter_tb_top.sv */
// Self-checking bench for the blanking-interval data inserter
`default_nettype none
module vbi_data_inserter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, reg_write, reg_read, hsync_start, text_data_in, text_request;
    logic [3:0] reg_addr, tdel;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic [9:0] line_number, video_in, video_out, vid[0:1727], pin[0:1727];
    logic [15:0] seed = 16'h0063, vseed = 16'h0063;
    logic [47:0] pre;
    logic [13:0] pay;
    int n_errors = 0, check_count = 0, cyc = 0, rise_t, req_w, dev_t, off0;
    localparam logic [7:0] MASKS[5] = '{8'hFF, 8'h3F, 8'h81, 8'h1F, 8'hFF};
    vbi_data_inserter #(.LINE_CLOCKS(1728)) vbi_data_inserter_i (.clock(clock), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .hsync_start(hsync_start), .line_number(line_number), .video_in(video_in),
        .text_data_in(text_data_in), .text_request(text_request), .video_out(video_out));
    text_source_model text_source_model_i (.clock(clock), .text_request(text_request),
        .source_request_delay(tdel), .text_data_in(text_data_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // One line: hsync pulse, then record output and request per cycle
    task automatic run_line(input logic [9:0] ln);
        @(posedge clock);
        hsync_start <= 1'b1;
        line_number <= ln;
        @(posedge clock);
        hsync_start <= 1'b0;
        req_w = 0;
        dev_t = 0;
        for (int i = 0; i < 1727; i++)
        begin
            #1 vid[i] = video_out;
            pin[i] = video_in;
            if (text_request === 1'b1 && req_w++ == 0) rise_t = i;
            if (i > 0 && dev_t == 0 && vid[i] !== pin[i - 1]) dev_t = i;
            @(posedge clock);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #10 clock = !clock;
    end
    // Random video keeps the pass-through paths honest
    always @(posedge clock)
    begin
        vseed = lfsr(vseed);
        video_in <= vseed[9:0];
        if (++cyc == 40000)
        begin
            n_errors++;
            test_done;
        end
    end
    initial
    begin
        {rst, reg_write, reg_read, hsync_start, reg_addr, reg_wdata, line_number, video_in, tdel} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 5; a++)
        begin
            rd(a, v);
            chk(v, 8'h00);
            seed = lfsr(seed);
            wr(a, seed[7:0]);
            rd(a, v);
            chk(v & MASKS[a], seed[7:0] & MASKS[a]);
        end
        wr(4'h9, 8'hFF);
        rd(4'h9, v);
        chk(v, 8'h00);
        $display("register test done");
        seed = lfsr(seed);
        pay = seed[13:0];
        pay[3] = ~^pay[2:0];
        pre = {vbi_data_inserter_pkg::WSS_RUNIN, vbi_data_inserter_pkg::WSS_START};
        wr(4'h0, pay[7:0]);
        wr(4'h1, {2'h0, pay[13:8]});
        wr(4'h3, 8'h00);
        wr(4'h2, 8'h81);
        run_line(10'h017);
        for (int k = 0; k < 62; k++)
            chk(vid[vbi_data_inserter_pkg::WSS_START_CLK + 4 + 5 * k],
                (k < 48 ? pre[47 - k] : pay[k - 48]) ? 10'h1F4 : 10'h0F0);
        chk(vid[1200], pin[1199]);
        rd(4'h5, v);
        chk(v, 8'h09);
        foreach (MASKS[m]) if (m < 3)
        begin
            wr(4'h2, m == 0 ? 8'h80 : m == 1 ? 8'h01 : 8'h81);
            run_line(m == 2 ? 10'h016 : 10'h017);
            chk(dev_t, 0);
        end
        $display("signaling test done");
        for (int j = 0; j < 3; j++)
        begin
            seed = lfsr(seed);
            tdel = j == 0 ? 4'h0 : j == 1 ? 4'hF : seed[3:0];
            wr(4'h4, 8'h01 << seed[6:4]);
            wr(4'h3, {4'h1, tdel});
            run_line(10'h007 + seed[6:4]);
            if (j == 0) off0 = rise_t;
            chk(req_w, 1402);
            chk(vid[600] >= 10'h0F0 && vid[600] <= 10'h1F4, 1);
            chk(rise_t + tdel, off0);
            run_line(10'h007 + ((seed[6:4] + 3'h1) % 8));
            chk(req_w, 0);
            wr(4'h3, {4'h0, tdel});
            run_line(10'h007 + seed[6:4]);
            chk(req_w, 0);
        end
        $display("teletext test done");
        test_done;
    end
endmodule // vbi_data_inserter_tb_top
`default_nettype wire
